/* File: logic/synth_latch_power_control.sv */
// Latch bank and power-down control of a serially programmed frequency synthesizer
// Functional notes
// - Feedback word: gain bit 21, divisor 20..8, reserved 7..2, code 1,0.
// - Reference word: band clock 21..20, test 19, precision 18, pulse 17..16, divisor 15..2.
// - First control word after power-up, unless request one with sync zero, powers part up, starts bias settling.
// - Power-down without feedback update resumes in same band, relocks.
// - Destination code 0,0 loads the control latch on strobe rise.
// - Request one with sync zero powers down immediately.
// - Request and sync one: power down on second divider edge after strobe.
// - Chip enable low disables device at once regardless of bits.
// - Power-down loads counters, tristates pump, resets lock, mutes outputs, stops buffer.
// - Serial input keeps working during power-down.
// - Current one from low three select bits, two from high three.
// - Mute-until-locked keeps outputs off until lock reported.
// - Gain one selects current two, zero selects current one.
// - Gain select follows the latest write from either latch.
// - 24-bit shift on serial clock rise, MSB first, transfer on strobe rise.
// - Counter clear bit holds reference and feedback counters in reset.
`timescale 1ns/1ps
`default_nettype none
module synth_latch_power_control
  import synth_latch_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   sclk_pin,
  input  wire logic                   sdata_pin,
  input  wire logic                   latch_strobe,
  input  wire logic                   chip_enable_pin,
  input  wire logic                   ref_div_out,
  input  wire logic                   lock_detect,
  output logic                        powered_up,
  output logic                        bias_settle_start,
  output logic                        counters_load,
  output logic                        pump_tristate,
  output logic                        lock_detect_reset,
  output logic                        outputs_enable,
  output logic                        ref_buffer_enable,
  output logic [2:0]                  pump_current,
  output logic                        pump_gain_select,
  output logic [12:0]                 feedback_divisor_value,
  output logic [13:0]                 ref_divisor_value,
  output logic [1:0]                  band_clock_div,
  output logic                        factory_test_select,
  output logic                        lock_precision_select,
  output logic [1:0]                  pulse_width,
  output logic [1:0]                  output_power_level,
  output logic [1:0]                  core_power_level,
  output logic [2:0]                  mux_select,
  output logic                        phase_polarity,
  output logic                        band_select_start
);
  import synth_latch_pkg::*;

  // Power states, one-hot
  typedef enum logic [3:0] {
    PS_OFF  = 4'h1,
    PS_ON   = 4'h2,
    PS_WAIT = 4'h4,
    PS_DOWN = 4'h8
  } pwr_state_t;

  // Captured word and its transfer pulse from the shifter
  serial_word_if sw ();

  // Latch copies, shared gain and power-down tracking
  logic [WORD_W-1:0] ctl_r;
  logic [WORD_W-1:0] fb_r;
  logic [WORD_W-1:0] ref_r;
  logic              gain_r;
  logic [1:0]        sync_r;
  logic [1:0]        sync2_r;
  logic              ref_d_r;
  logic [1:0]        edge_cnt_r;
  pwr_state_t        state_r;
  pwr_state_t        state_nxt;

  // Destination decode used by every latch
  function automatic logic dest_is(input logic [WORD_W-1:0] w, input logic [1:0] code);
    dest_is = (w[DEST_LSB+1:DEST_LSB] == code);
  endfunction : dest_is

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Refuse a field layout that overruns the word
  // or a synchronous edge count of zero
  if (FB_DIV_LSB + FB_DIV_W > WORD_W || REF_DIV_LSB + REF_DIV_W > WORD_W ||
      CTL_SYNC_BIT >= WORD_W || SYNC_EDGES == 2'h0)
  begin : g_layout_bad
    $error("latch field layout does not fit the serial word");
  end

  // ----------------------------------------------------------------
  // Serial input (runs in every power state)
  // ----------------------------------------------------------------
  serial_word_shifter u_shift (
    .core_clk   (core_clk),
    .srst       (srst),
    .sclk_pin   (sclk_pin),
    .sdata_pin  (sdata_pin),
    .strobe_pin (latch_strobe),
    .wout       (sw)
  );

  // Transfer pulses per destination; test code words match none
  logic xfer_ctl;
  logic xfer_fb;
  logic xfer_ref;
  assign xfer_ctl = sw.xfer & dest_is(sw.word, DEST_CONTROL);
  assign xfer_fb  = sw.xfer & dest_is(sw.word, DEST_FEEDBACK);
  assign xfer_ref = sw.xfer & dest_is(sw.word, DEST_REFERENCE);

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  // Each latch loads only on its own destination code
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctl_r <= '0;
      fb_r  <= '0;
      ref_r <= '0;
    end
    else
    begin
      if (xfer_ctl)
        ctl_r <= sw.word;
      if (xfer_fb)
        fb_r <= sw.word;
      if (xfer_ref)
        ref_r <= sw.word;
    end
  end

  // Shared gain bit follows the most recent writer
  always_ff @(posedge core_clk)
  begin
    if (srst)
      gain_r <= 1'b0;
    else if (xfer_ctl)
      gain_r <= sw.word[CTL_GAIN_BIT];
    else if (xfer_fb)
      gain_r <= sw.word[FB_GAIN_BIT];
  end

  // ----------------------------------------------------------------
  // Power-down control
  // ----------------------------------------------------------------
  // Synchronise chip enable and divider output
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync_r  <= 2'h0;
      sync2_r <= 2'h0;
      ref_d_r <= 1'b0;
    end
    else
    begin
      sync_r  <= {ref_div_out, chip_enable_pin};
      sync2_r <= sync_r;
      ref_d_r <= sync2_r[1];
    end
  end

  // Enable level, divider rise and request fields of the word
  logic ce_ok;
  logic ref_rise;
  logic req_bit;
  logic sync_bit;
  assign ce_ok    = sync2_r[0];
  assign ref_rise = sync2_r[1] & ~ref_d_r;
  assign req_bit  = sw.word[CTL_REQ_BIT];
  assign sync_bit = sw.word[CTL_SYNC_BIT];

  // Count divider edges after a synchronous request
  always_ff @(posedge core_clk)
  begin
    if (srst)
      edge_cnt_r <= 2'h0;
    else if (state_r != PS_WAIT)
      edge_cnt_r <= 2'h0;
    else if (xfer_ctl)
      edge_cnt_r <= 2'h0;
    else if (ref_rise)
      edge_cnt_r <= edge_cnt_r + 2'h1;
  end

  // Power state transitions
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PS_OFF:
        if (xfer_ctl && !req_bit)
          state_nxt = PS_ON;
        else if (xfer_ctl && sync_bit)
          state_nxt = PS_WAIT;
      PS_ON:
        if (xfer_ctl && req_bit && !sync_bit)
          state_nxt = PS_DOWN;
        else if (xfer_ctl && req_bit && sync_bit)
          state_nxt = PS_WAIT;
      PS_WAIT:
        if (xfer_ctl && !req_bit)
          state_nxt = PS_ON;
        else if (xfer_ctl && !sync_bit)
          state_nxt = PS_DOWN;
        else if (!xfer_ctl && ref_rise && edge_cnt_r == SYNC_EDGES - 2'h1)
          state_nxt = PS_DOWN;
      PS_DOWN:
        if (xfer_ctl && !req_bit)
          state_nxt = PS_ON;
      default:
        state_nxt = PS_OFF;
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_r <= PS_OFF;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Running only when on or waiting with enable high
  logic active;
  assign active = (state_nxt == PS_ON || state_nxt == PS_WAIT) && ce_ok;

  // Power and down-state effects
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      powered_up        <= 1'b0;
      bias_settle_start <= 1'b0;
      counters_load     <= 1'b1;
      pump_tristate     <= 1'b1;
      lock_detect_reset <= 1'b1;
      outputs_enable    <= 1'b0;
      ref_buffer_enable <= 1'b0;
      band_select_start <= 1'b0;
    end
    else
    begin
      powered_up        <= active;
      bias_settle_start <= (state_r == PS_OFF) && (state_nxt != PS_OFF);
      counters_load     <= !active || ctl_r[CTL_CLEAR_BIT];
      pump_tristate     <= !active || ctl_r[CTL_TRI_BIT];
      lock_detect_reset <= !active;
      ref_buffer_enable <= active;
      outputs_enable    <= active && (!ctl_r[CTL_MUTE_BIT] || lock_detect);
      // Band reselect only on a feedback write while running; wake keeps band
      band_select_start <= xfer_fb && active;
    end
  end

  // Field outputs
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pump_current           <= 3'h0;
      pump_gain_select       <= 1'b0;
      feedback_divisor_value <= 13'h0;
      ref_divisor_value      <= 14'h0;
      band_clock_div         <= 2'h0;
      factory_test_select    <= 1'b0;
      lock_precision_select  <= 1'b0;
      pulse_width            <= 2'h0;
      output_power_level     <= 2'h0;
      core_power_level       <= 2'h0;
      mux_select             <= 3'h0;
      phase_polarity         <= 1'b0;
    end
    else
    begin
      pump_current           <= gain_r ? ctl_r[CTL_CUR2_LSB+:3] : ctl_r[CTL_CUR1_LSB+:3];
      pump_gain_select       <= gain_r;
      feedback_divisor_value <= fb_r[FB_DIV_LSB+:FB_DIV_W];
      ref_divisor_value      <= ref_r[REF_DIV_LSB+:REF_DIV_W];
      band_clock_div         <= ref_r[REF_BAND_LSB+:2];
      factory_test_select    <= ref_r[REF_TEST_BIT];
      lock_precision_select  <= ref_r[REF_PREC_BIT];
      pulse_width            <= ref_r[REF_PULSE_LSB+:2];
      output_power_level     <= ctl_r[CTL_OPWR_LSB+:2];
      core_power_level       <= ctl_r[CTL_CORE_LSB+:2];
      mux_select             <= ctl_r[CTL_MUX_LSB+:3];
      phase_polarity         <= ctl_r[CTL_POL_BIT];
    end
  end
endmodule : synth_latch_power_control
`default_nettype wire

/* File: logic/synth_latch_pkg.sv */
// Package of field layouts, destination codes and timing constants for the synthesizer latches
`default_nettype none
package synth_latch_pkg;
  localparam int unsigned WORD_W          = 24;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // Destination codes in bits 1..0
  localparam logic [1:0]  DEST_CONTROL    = 2'h0;
  localparam logic [1:0]  DEST_REFERENCE  = 2'h1;
  localparam logic [1:0]  DEST_FEEDBACK   = 2'h2;
  localparam logic [1:0]  DEST_TEST       = 2'h3;
  localparam int unsigned DEST_LSB        = 0;
  // Control latch fields
  localparam int unsigned CTL_SYNC_BIT    = 21;
  localparam int unsigned CTL_REQ_BIT     = 20;
  localparam int unsigned CTL_CUR2_LSB    = 17;
  localparam int unsigned CTL_CUR1_LSB    = 14;
  localparam int unsigned CTL_OPWR_LSB    = 12;
  localparam int unsigned CTL_MUTE_BIT    = 11;
  localparam int unsigned CTL_GAIN_BIT    = 10;
  localparam int unsigned CTL_TRI_BIT     = 9;
  localparam int unsigned CTL_POL_BIT     = 8;
  localparam int unsigned CTL_MUX_LSB     = 5;
  localparam int unsigned CTL_CLEAR_BIT   = 4;
  localparam int unsigned CTL_CORE_LSB    = 2;
  // Feedback latch fields
  localparam int unsigned FB_GAIN_BIT     = 21;
  localparam int unsigned FB_DIV_LSB      = 8;
  localparam int unsigned FB_DIV_W        = 13;
  // Reference latch fields
  localparam int unsigned REF_BAND_LSB    = 20;
  localparam int unsigned REF_TEST_BIT    = 19;
  localparam int unsigned REF_PREC_BIT    = 18;
  localparam int unsigned REF_PULSE_LSB   = 16;
  localparam int unsigned REF_DIV_LSB     = 2;
  localparam int unsigned REF_DIV_W       = 14;
  // Power-down sync: edges of divider output after strobe
  localparam logic [1:0]  SYNC_EDGES      = 2'h2;
  // Settling intervals the controller keeps (for reference)
  localparam int unsigned SETTLE_LARGE_US = 15000;
  localparam int unsigned SETTLE_SMALL_US = 600;
endpackage : synth_latch_pkg
`default_nettype wire

/* File: logic/serial_word_if.sv */
// Interface carrying a captured serial word and its transfer pulse
`timescale 1ns/1ps
`default_nettype none
interface serial_word_if;
  logic [23:0] word;
  logic        xfer;
  modport src (output word, output xfer);
  modport dst (input word, input xfer);
endinterface : serial_word_if
`default_nettype wire

/* File: logic/serial_word_shifter.sv */
// Three-wire serial shift register with synchronised pins and strobe edge transfer
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter
  import synth_latch_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        sclk_pin,
  input  wire logic        sdata_pin,
  input  wire logic        strobe_pin,
  serial_word_if.src       wout
);
  logic [2:0]        s1_r;
  logic [2:0]        s2_r;
  logic              sclk_d_r;
  logic              strobe_d_r;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] word_r;
  logic              xfer_r;

  // Two-stage synchronisers on the pins
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end
    else
    begin
      s1_r <= {strobe_pin, sdata_pin, sclk_pin};
      s2_r <= s1_r;
    end
  end

  // Shift MSB first on serial clock rise, hand over on strobe rise
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sclk_d_r   <= 1'b0;
      strobe_d_r <= 1'b0;
      shift_r    <= '0;
      word_r     <= '0;
      xfer_r     <= 1'b0;
    end
    else
    begin
      sclk_d_r   <= s2_r[0];
      strobe_d_r <= s2_r[2];
      xfer_r     <= s2_r[2] & ~strobe_d_r;
      if (s2_r[0] & ~sclk_d_r)
        shift_r <= {shift_r[WORD_W-2:0], s2_r[1]};
      if (s2_r[2] & ~strobe_d_r)
        word_r <= shift_r;
    end
  end

  assign wout.word = word_r;
  assign wout.xfer = xfer_r;
endmodule : serial_word_shifter
`default_nettype wire

/* File: test/synth_latch_props.sv */
// Checker of power-down and latch behaviour at the block ports
`timescale 1ns/1ps
`default_nettype none
module synth_latch_props
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        latch_strobe,
  input wire logic        chip_enable_pin,
  input wire logic        ref_div_out,
  input wire logic        powered_up,
  input wire logic        bias_settle_start,
  input wire logic        counters_load,
  input wire logic        pump_tristate,
  input wire logic        lock_detect_reset,
  input wire logic        outputs_enable,
  input wire logic        ref_buffer_enable,
  input wire logic        pump_gain_select,
  input wire logic [12:0] feedback_divisor_value,
  input wire logic [13:0] ref_divisor_value,
  input wire logic        band_select_start
);
  logic [3:0] le_age_r;
  logic [3:0] ref_age_r;
  logic       le_d_r;
  logic       ref_d_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles since the last strobe rise, saturating
  always_ff @(posedge core_clk)
  begin
    le_d_r <= latch_strobe;
    le_age_r <= (srst || (latch_strobe && !le_d_r)) ? 4'h0 : le_age_r + {3'h0, le_age_r != 4'hF};
  end
  // Cycles since the last divider rise, saturating
  always_ff @(posedge core_clk)
  begin
    ref_d_r <= ref_div_out;
    ref_age_r <= (srst || (ref_div_out && !ref_d_r)) ? 4'h0 : ref_age_r + {3'h0, ref_age_r != 4'hF};
  end
  property p_down_state;
    !powered_up |-> counters_load && lock_detect_reset && !ref_buffer_enable && !outputs_enable;
  endproperty
  a_down_state: assert property (p_down_state) else $error("down state outputs wrong");
  property p_down_pump;
    !powered_up |-> pump_tristate;
  endproperty
  a_down_pump: assert property (p_down_pump) else $error("pump not tristated");
  property p_ce_off;
    !chip_enable_pin [*5] |-> !ref_buffer_enable && !outputs_enable;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("enable low ignored");
  property p_settle_pulse;
    bias_settle_start |-> ##[0:1] powered_up ##1 !bias_settle_start;
  endproperty
  a_settle_pulse: assert property (p_settle_pulse) else $error("settle pulse wrong");
  property p_band_pulse;
    band_select_start |=> !band_select_start;
  endproperty
  a_band_pulse: assert property (p_band_pulse) else $error("band pulse too long");
  property p_fields_hold;
    le_age_r == 4'hF |-> $stable(feedback_divisor_value) && $stable(ref_divisor_value) && $stable(pump_gain_select);
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("field moved without write");
  property p_down_cause;
    $fell(powered_up) |-> le_age_r < 4'hC || ref_age_r < 4'h8 || !chip_enable_pin;
  endproperty
  a_down_cause: assert property (p_down_cause) else $error("power-down without cause");
  property p_out_needs_on;
    outputs_enable |-> powered_up && ref_buffer_enable;
  endproperty
  a_out_needs_on: assert property (p_out_needs_on) else $error("outputs on while off");
  c_settle: cover property (bias_settle_start);
  c_band: cover property (band_select_start);
  c_down: cover property ($fell(powered_up));
endmodule : synth_latch_props
bind synth_latch_power_control synth_latch_props i_synth_latch_props (.core_clk, .srst, .latch_strobe,
  .chip_enable_pin, .ref_div_out, .powered_up, .bias_settle_start, .counters_load, .pump_tristate,
  .lock_detect_reset, .outputs_enable, .ref_buffer_enable, .pump_gain_select, .feedback_divisor_value,
  .ref_divisor_value, .band_select_start);
`default_nettype wire

/* File: test/host_model.sv */
// Host controller model driving three-wire serial writes
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic core_clk,
  output logic      sclk_pin,
  output logic      sdata_pin,
  output logic      latch_strobe
);
  initial
  begin
    sclk_pin = 1'b0;
    sdata_pin = 1'b0;
    latch_strobe = 1'b0;
  end
  // Shift one word MSB first, then pulse the strobe
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      @(negedge core_clk);
      sdata_pin = w[i];
      repeat (4) @(negedge core_clk);
      sclk_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      sclk_pin = 1'b0;
    end
    sdata_pin = ~w[0];
    repeat (4) @(negedge core_clk);
    latch_strobe = 1'b1;
    repeat (4) @(negedge core_clk);
    latch_strobe = 1'b0;
  endtask : send
endmodule : host_model
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench of the synthesizer latch and power-down block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import synth_latch_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic chip_enable_pin = 1'b1;
  logic ref_div_out = 1'b0;
  logic lock_detect = 1'b0;
  wire logic sclk_pin, sdata_pin, latch_strobe;
  logic powered_up, bias_settle_start, counters_load, pump_tristate, lock_detect_reset;
  logic outputs_enable, ref_buffer_enable, pump_gain_select, lock_precision_select, band_select_start;
  logic factory_test_select, phase_polarity;
  logic [2:0] pump_current, mux_select;
  logic [12:0] feedback_divisor_value;
  logic [13:0] ref_divisor_value;
  logic [1:0] band_clock_div, pulse_width, output_power_level, core_power_level;
  int error_cnt = 0;
  int checks = 0;
  int n_bias = 0;
  int n_band = 0;
  always #12.5 core_clk = ~core_clk;
  host_model i_host_model (.core_clk, .sclk_pin, .sdata_pin, .latch_strobe);
  synth_latch_power_control i_synth_latch_power_control (.core_clk, .srst, .sclk_pin, .sdata_pin,
    .latch_strobe, .chip_enable_pin, .ref_div_out, .lock_detect, .powered_up, .bias_settle_start,
    .counters_load, .pump_tristate, .lock_detect_reset, .outputs_enable, .ref_buffer_enable,
    .pump_current, .pump_gain_select, .feedback_divisor_value, .ref_divisor_value, .band_clock_div,
    .factory_test_select, .lock_precision_select, .pulse_width, .output_power_level,
    .core_power_level, .mux_select, .phase_polarity, .band_select_start);
  // Count one-cycle pulses away from the launching edge
  always @(negedge core_clk)
  begin
    if (bias_settle_start === 1'b1) n_bias++;
    if (band_select_start === 1'b1) n_band++;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic put(input logic [23:0] w);
    i_host_model.send(w);
    cyc(10);
  endtask : put
  task automatic wait_pu(input logic v);
    int k;
    k = 0;
    while (powered_up !== v)
    begin
      cyc(1);
      k++;
      if (k > 40)
      begin
        chk("powered_up", powered_up, v);
        report_and_stop();
      end
    end
    chk("powered_up", powered_up, v);
  endtask : wait_pu
  task automatic refp;
    ref_div_out = 1'b1;
    cyc(4);
    ref_div_out = 1'b0;
    cyc(4);
  endtask : refp
  function automatic logic [23:0] ctl(input logic rq, sy, mu, gn, cl, input logic [2:0] c2, c1);
    return {2'h0, sy, rq, c2, c1, 2'h0, mu, gn, 5'h00, cl, 2'h0, DEST_CONTROL};
  endfunction : ctl
  // Ordered power-up: reference, control, wait, feedback
  task automatic t_power_up;
    chk("load_rst", counters_load, 1'b1);
    put({2'h0, 2'h2, 1'b0, 1'b1, 2'h1, 14'h2A5B, DEST_REFERENCE});
    chk("ref_div", ref_divisor_value, 14'h2A5B);
    chk("band_clk", band_clock_div, 2'h2);
    chk("prec", lock_precision_select, 1'b1);
    chk("pulse", pulse_width, 2'h1);
    chk("test0", factory_test_select, 1'b0);
    chk("pu_ref", powered_up, 1'b0);
    put(ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5, 3'h3));
    chk("pu_ctl", powered_up, 1'b1);
    chk("bias", n_bias, 1);
    chk("cur_one", pump_current, 3'h3);
    chk("load_run", counters_load, 1'b0);
    chk("muted", outputs_enable, 1'b0);
    lock_detect = 1'b1;
    cyc(3);
    chk("unmuted", outputs_enable, 1'b1);
    cyc(SETTLE_SMALL_US * 1000 / CLK_PERIOD_NS);
    put({2'h0, 1'b1, 13'h1ABC, 6'h00, DEST_FEEDBACK});
    chk("fb_div", feedback_divisor_value, 13'h1ABC);
    chk("gain_fb", pump_gain_select, 1'b1);
    chk("cur_two", pump_current, 3'h5);
    chk("band_sel", n_band, 1);
    put({22'h3FFFFF, DEST_TEST});
    chk("ref_keep", ref_divisor_value, 14'h2A5B);
    chk("fb_keep", feedback_divisor_value, 13'h1ABC);
  endtask : t_power_up
  // Immediate power-down, write while down, wake without feedback change
  task automatic t_async;
    put(ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 3'h3));
    wait_pu(1'b0);
    chk("load_dn", counters_load, 1'b1);
    chk("tri_dn", pump_tristate, 1'b1);
    chk("ld_rst_dn", lock_detect_reset, 1'b1);
    chk("buf_dn", ref_buffer_enable, 1'b0);
    put({2'h0, 2'h1, 1'b1, 1'b0, 2'h2, 14'h0123, DEST_REFERENCE});
    chk("ref_dn", ref_divisor_value, 14'h0123);
    chk("test1", factory_test_select, 1'b1);
    chk("band_dn", band_clock_div, 2'h1);
    chk("pulse_dn", pulse_width, 2'h2);
    // No feedback write while down
    put(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 3'h3));
    wait_pu(1'b1);
    chk("fb_same", feedback_divisor_value, 13'h1ABC);
    chk("no_reband", n_band, 1);
    chk("gain_ctl", pump_gain_select, 1'b0);
    chk("cur_back", pump_current, 3'h3);
  endtask : t_async
  // Power-down on the second divider rise after the strobe
  task automatic t_sync;
    put(ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h5, 3'h3));
    chk("pu_wait0", powered_up, 1'b1);
    refp();
    cyc(4);
    chk("pu_wait1", powered_up, 1'b1);
    refp();
    wait_pu(1'b0);
    put(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 3'h3));
    wait_pu(1'b1);
    chk("clr_load", counters_load, 1'b1);
    put(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 3'h3));
    chk("clr_off", counters_load, 1'b0);
  endtask : t_sync
  // Spare control fields reach their outputs; three-state bit forces the pump off
  task automatic t_fields;
    put({2'h0, 1'b0, 1'b0, 3'h5, 3'h3, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 3'h6, 1'b0, 2'h1, DEST_CONTROL});
    chk("opwr", output_power_level, 2'h2);
    chk("core_pwr", core_power_level, 2'h1);
    chk("mux", mux_select, 3'h6);
    chk("polarity", phase_polarity, 1'b1);
    chk("tri_on", pump_tristate, 1'b1);
    chk("pu_tri", powered_up, 1'b1);
    put(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5, 3'h3));
    chk("tri_off", pump_tristate, 1'b0);
    chk("ref_hold", ref_divisor_value, 14'h0123);
  endtask : t_fields
  // Chip enable low disables at once
  task automatic t_ce;
    chip_enable_pin = 1'b0;
    cyc(6);
    chk("ce_buf", ref_buffer_enable, 1'b0);
    chk("ce_out", outputs_enable, 1'b0);
    chk("ce_pu", powered_up, 1'b0);
    chip_enable_pin = 1'b1;
    cyc(6);
    chk("ce_back", ref_buffer_enable, 1'b1);
  endtask : t_ce
  initial
  begin
    cyc(16);
    srst = 1'b0;
    cyc(2);
    t_power_up();
    t_async();
    t_sync();
    t_fields();
    t_ce();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
